// >>> include/sfrt_params.svh
// constants of the resume / reset / parameter-table command slice
// assumes a 50 MHz system clock; included by bare name
`ifndef SFRT_PARAMS_SVH
`define SFRT_PARAMS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define SFRT_CLK_MHZ 50

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFRT_OP_RESUME 8'h30
`define SFRT_OP_NOP 8'h00
`define SFRT_OP_RST_ARM 8'h66
`define SFRT_OP_RST 8'h99
`define SFRT_OP_TBL_RD 8'h5a
`define SFRT_OP_WRITE_LATCH_ARM 8'h06

// ----------------------------------------------------------------
// link bit positions within a frame
// ----------------------------------------------------------------
`define SFRT_OPC_BITS 6'h08
`define SFRT_ADDR_END 6'h1f
`define SFRT_DUMMY_END 6'h27
`define SFRT_DATA_FIRST 6'h28
`define SFRT_DATA_LAST 6'h2f
`define SFRT_STEP_SINGLE 6'h01
`define SFRT_STEP_QUAD 6'h04

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFRT_RESUME_GAP_US 1000
`define SFRT_RESUME_GAP_CYC (`SFRT_RESUME_GAP_US * `SFRT_CLK_MHZ)
`define SFRT_RECOV_IDLE_NS 30000
`define SFRT_RECOV_PGM_NS 40000
`define SFRT_RECOV_ERS_NS 60000
`define SFRT_RECOV_IDLE_CYC ((`SFRT_RECOV_IDLE_NS * `SFRT_CLK_MHZ + 999) / 1000)
`define SFRT_RECOV_PGM_CYC ((`SFRT_RECOV_PGM_NS * `SFRT_CLK_MHZ + 999) / 1000)
`define SFRT_RECOV_ERS_CYC ((`SFRT_RECOV_ERS_NS * `SFRT_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// parameter table header contents
// ----------------------------------------------------------------
`define SFRT_TBL_HDR_BYTES 24
`define SFRT_TBL_SIG0 8'h53
`define SFRT_TBL_SIG1 8'h46
`define SFRT_TBL_SIG2 8'h44
`define SFRT_TBL_SIG3 8'h50
`define SFRT_TBL_REV_MINOR 8'h00
`define SFRT_TBL_REV_MAJOR 8'h01
`define SFRT_TBL_NUM_HDRS 8'h01
`define SFRT_TBL_UNUSED 8'hff
`define SFRT_TBL_STD_ID 8'h00
`define SFRT_TBL_STD_LEN 8'h09
`define SFRT_TBL_STD_PTR 24'h000030
`define SFRT_TBL_VND_LEN 8'h04
`define SFRT_TBL_VND_PTR 24'h000060

`endif

// >>> include/sfrt_pkg.sv
// types shared by the command slice and its table memory
// no assumptions beyond a SystemVerilog compiler
package sfrt_pkg;
   typedef logic [7:0] sfrt_byte_t;
   typedef logic [23:0] sfrt_addr_t;
   typedef logic [3:0] sfrt_nibble_t;
   typedef enum logic {st_ready, st_recover} sfrt_state_t;
endpackage : sfrt_pkg

// >>> include/sfrt_rom_if.sv
// carrier between the link logic and the parameter-table memory
// both ends run on the link clock
`timescale 1ns/1ps
interface sfrt_rom_if;
   sfrt_pkg::sfrt_addr_t addr;
   sfrt_pkg::sfrt_byte_t data;
   modport mem (input addr, output data);
   modport user (output addr, input data);
endinterface : sfrt_rom_if

// >>> logic/sfrt_cmd.sv
// resume / no-op / software reset / parameter-table read command slice
// link side on the host's serial clock, status side on the 50 MHz clock;
// suspend events, busy and mode levels come from the rest of the device
//
// What this block does
// - resume opcode in its own frame restarts the suspended erase or program.
// - accepted resume clears whichever suspend flag was set.
// - busy stays set after resume until the engine reports completion.
// - resume needs no prior write-latch arm command.
// - resume is ignored while performance enhance mode is on.
// - no-op cancels a pending reset arm and does nothing else.
// - short commands take 8 single clocks or 2 quad clocks.
// - reset runs only if reset arm was the command just before.
// - software reset returns to standby with volatile state at defaults.
// - software reset aborts a running program or erase.
// - recovery time after reset depends on the interrupted operation.
// - table read, single-line mode only: opcode, three address bytes, dummy byte, then data out.
// - raising chip select stops table data output at once.
// - header-count byte at 06h reads 01h.
// - first header id at 08h reads 00h; second at 10h is maker code.
// - header length bytes read 09h and 04h.
// - table pointers read 000030h and 000060h.
// - erase-suspend flag set on suspend, cleared on resume.
// - program-suspend flag set on suspend, cleared on resume.
`timescale 1ns/1ps
`include "sfrt_params.svh"
module sfrt_cmd #(
   parameter logic [15:0] RESUME_GAP_CYC = 16'(`SFRT_RESUME_GAP_CYC)
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic cs_n,
   input wire sfrt_pkg::sfrt_nibble_t sio_in,
   output logic [3:0] sio_out,
   output logic [3:0] sio_oe,
   input wire logic qpi_mode,
   input wire logic perf_mode,
   input wire logic erase_suspend_evt,
   input wire logic program_suspend_evt,
   input wire logic engine_busy,
   input wire logic engine_erasing,
   input wire logic engine_done_evt,
   output logic erase_suspended_flag,
   output logic program_suspended_flag,
   output logic busy,
   output logic resume_req,
   output logic abort_req,
   output logic soft_reset,
   output logic dev_ready,
   output logic suspend_ok
);
   import sfrt_pkg::*;

   // ----------------------------------------------------------------
   // link side: frame bit counter and shifter
   // ----------------------------------------------------------------
   sfrt_rom_if rom ();

   logic qm_s1_r;
   logic qm_s2_r;
   logic [5:0] cnt_r;
   logic [23:0] sh_r;
   logic is_rd_r;
   sfrt_addr_t addr_r;
   sfrt_byte_t out_sh_r;
   sfrt_byte_t opc_r;
   logic opc_tgl_r;
   logic long_tgl_r;
   logic so_r;
   logic drive_r;

   // chip select high holds the frame logic in reset
   wire link_rst_n = nrst & ~cs_n;
   wire [5:0] step = qm_s2_r ? `SFRT_STEP_QUAD : `SFRT_STEP_SINGLE;
   // upper lines ignored in single-line mode
   wire [23:0] sh_nxt = qm_s2_r ? {sh_r[19:0], sio_in} : {sh_r[22:0], sio_in[0]};
   wire [5:0] cnt_sum = cnt_r + step;
   wire [5:0] cnt_nxt = (cnt_r >= `SFRT_DATA_LAST) ? `SFRT_DATA_FIRST : cnt_sum;
   wire opc_done = cnt_sum == `SFRT_OPC_BITS;
   wire past_opc = cnt_r == `SFRT_OPC_BITS;
   wire rd_start = opc_done & ~qm_s2_r & (sh_nxt[7:0] == `SFRT_OP_TBL_RD);
   wire addr_done = is_rd_r & (cnt_r == `SFRT_ADDR_END);
   wire byte_load = is_rd_r & ((cnt_r == `SFRT_DUMMY_END) | (cnt_r == `SFRT_DATA_LAST));
   wire in_data = is_rd_r & (cnt_r >= `SFRT_DATA_FIRST);
   wire out_bit = out_sh_r[3'h7 - cnt_r[2:0]];

   assign rom.addr = addr_r;

   sfrt_param_rom u_rom (
      .rclk(link_clk),
      .rom(rom.mem)
   );

   // mode level from the system side
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         qm_s1_r <= 1'b0;
         qm_s2_r <= 1'b0;
      end else begin
         qm_s1_r <= qpi_mode;
         qm_s2_r <= qm_s1_r;
      end
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cnt_r <= 6'h00;
         sh_r <= 24'h000000;
      end else begin
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
      end
   end

   // ----------------------------------------------------------------
   // link side: table read address and data
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         is_rd_r <= 1'b0;
      end else if (rd_start) begin
         is_rd_r <= 1'b1;
      end
   end

   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         addr_r <= 24'h000000;
      end else if (addr_done) begin
         addr_r <= sh_nxt;
      end else if (byte_load) begin
         addr_r <= addr_r + 24'h000001;
      end
   end

   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         out_sh_r <= 8'hff;
      end else if (byte_load) begin
         out_sh_r <= rom.data;
      end
   end

   // data launched on the falling edge, msb first
   always_ff @(negedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         so_r <= 1'b0;
         drive_r <= 1'b0;
      end else begin
         so_r <= out_bit;
         drive_r <= in_data;
      end
   end

   assign sio_out = {2'b00, so_r, 1'b0};
   assign sio_oe = {2'b00, drive_r & ~cs_n, 1'b0};

   // ----------------------------------------------------------------
   // link side: opcode hand-off toggles
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         opc_r <= 8'h00;
         opc_tgl_r <= 1'b0;
         long_tgl_r <= 1'b0;
      end else begin
         if (opc_done) begin
            opc_r <= sh_nxt[7:0];
            opc_tgl_r <= ~opc_tgl_r;
         end
         if (past_opc) begin
            long_tgl_r <= ~long_tgl_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // system side: crossings
   // ----------------------------------------------------------------
   logic cs_s1_r, cs_s2_r, cs_s3_r, cs_s4_r;
   logic op_s1_r, op_s2_r, op_s3_r;
   logic lg_s1_r, lg_s2_r, lg_s3_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         cs_s4_r <= 1'b1;
         op_s1_r <= 1'b0;
         op_s2_r <= 1'b0;
         op_s3_r <= 1'b0;
         lg_s1_r <= 1'b0;
         lg_s2_r <= 1'b0;
         lg_s3_r <= 1'b0;
      end else begin
         cs_s1_r <= cs_n;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         cs_s4_r <= cs_s3_r;
         op_s1_r <= opc_tgl_r;
         op_s2_r <= op_s1_r;
         op_s3_r <= op_s2_r;
         lg_s1_r <= long_tgl_r;
         lg_s2_r <= lg_s1_r;
         lg_s3_r <= lg_s2_r;
      end
   end

   // ----------------------------------------------------------------
   // system side: command decode
   // ----------------------------------------------------------------
   sfrt_state_t state_r, state_nxt;
   sfrt_byte_t cmd_r;
   logic pend_r;
   logic long_r;
   logic arm_r;
   logic esb_r, psb_r, busy_r;
   logic resume_r, abort_r, rst_pulse_r;
   logic [11:0] rec_r;
   logic [15:0] gap_r;

   wire opc_evt = op_s2_r ^ op_s3_r;
   wire long_evt = lg_s2_r ^ lg_s3_r;
   // one stage later than the toggles so a late opcode is never missed
   wire frame_end = cs_s3_r & ~cs_s4_r;
   wire frame_cmd = frame_end & pend_r;
   // a short command counts only when the frame ends on its byte boundary
   wire exec = frame_cmd & ~long_r & (state_r == st_ready);
   wire is_resume = exec & (cmd_r == `SFRT_OP_RESUME);
   wire is_arm = exec & (cmd_r == `SFRT_OP_RST_ARM);
   wire is_rst = exec & (cmd_r == `SFRT_OP_RST);
   // no write-latch arm is looked for
   wire resume_go = is_resume & ~perf_mode & (esb_r | psb_r);
   wire rst_go = is_rst & arm_r;
   wire [11:0] rec_load = ~engine_busy ? 12'(`SFRT_RECOV_IDLE_CYC) :
      engine_erasing ? 12'(`SFRT_RECOV_ERS_CYC) : 12'(`SFRT_RECOV_PGM_CYC);
   wire rec_done = rec_r == 12'h000;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cmd_r <= 8'h00;
         pend_r <= 1'b0;
         long_r <= 1'b0;
      end else begin
         if (opc_evt) begin
            cmd_r <= opc_r;
         end
         pend_r <= opc_evt | (pend_r & ~frame_end);
         long_r <= long_evt | (long_r & ~opc_evt);
      end
   end

   // any completed frame other than a clean arm drops the arm, no-op included
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         arm_r <= 1'b0;
      end else if (frame_cmd | rst_go) begin
         arm_r <= is_arm;
      end
   end

   // ----------------------------------------------------------------
   // system side: suspend flags and busy
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         esb_r <= 1'b0;
         psb_r <= 1'b0;
      end else begin
         esb_r <= erase_suspend_evt | (esb_r & ~resume_go & ~rst_go);
         psb_r <= program_suspend_evt | (psb_r & ~resume_go & ~rst_go);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= resume_go | (busy_r & ~engine_done_evt & ~rst_go);
      end
   end

   // resume-to-suspend gap
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gap_r <= 16'h0000;
      end else if (resume_go) begin
         gap_r <= RESUME_GAP_CYC;
      end else if (gap_r != 16'h0000) begin
         gap_r <= gap_r - 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // system side: software reset and recovery
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_ready: begin
            if (rst_go) begin
               state_nxt = st_recover;
            end
         end
         st_recover: begin
            if (rec_done) begin
               state_nxt = st_ready;
            end
         end
         default: begin
            state_nxt = st_ready;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_r <= st_ready;
         rec_r <= 12'h000;
      end else begin
         state_r <= state_nxt;
         if (rst_go) begin
            rec_r <= rec_load;
         end else if (!rec_done) begin
            rec_r <= rec_r - 12'h001;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         resume_r <= 1'b0;
         abort_r <= 1'b0;
         rst_pulse_r <= 1'b0;
      end else begin
         resume_r <= resume_go;
         abort_r <= rst_go & (engine_busy | busy_r);
         rst_pulse_r <= rst_go;
      end
   end

   assign erase_suspended_flag = esb_r;
   assign program_suspended_flag = psb_r;
   assign busy = busy_r | engine_busy | (state_r == st_recover);
   assign resume_req = resume_r;
   assign abort_req = abort_r;
   assign soft_reset = rst_pulse_r;
   assign dev_ready = state_r == st_ready;
   assign suspend_ok = gap_r == 16'h0000;
endmodule : sfrt_cmd

// >>> logic/sfrt_param_rom.sv
// parameter-table header memory, registered read data
// assumes the address is stable one link clock before the data is used
`timescale 1ns/1ps
`include "sfrt_params.svh"
module sfrt_param_rom #(
   // maker code byte; value is arbitrary
   parameter logic [7:0] MAKER_ID = 8'h5e
) (
   input wire logic rclk,
   sfrt_rom_if.mem rom
);
   import sfrt_pkg::*;

   // ----------------------------------------------------------------
   // header contents
   // ----------------------------------------------------------------
   localparam sfrt_addr_t STD_PTR = `SFRT_TBL_STD_PTR;
   localparam sfrt_addr_t VND_PTR = `SFRT_TBL_VND_PTR;
   localparam sfrt_byte_t TBL [`SFRT_TBL_HDR_BYTES] = '{
      `SFRT_TBL_SIG0, `SFRT_TBL_SIG1, `SFRT_TBL_SIG2, `SFRT_TBL_SIG3,
      `SFRT_TBL_REV_MINOR, `SFRT_TBL_REV_MAJOR, `SFRT_TBL_NUM_HDRS, `SFRT_TBL_UNUSED,
      `SFRT_TBL_STD_ID, `SFRT_TBL_REV_MINOR, `SFRT_TBL_REV_MAJOR, `SFRT_TBL_STD_LEN,
      STD_PTR[7:0], STD_PTR[15:8], STD_PTR[23:16],
      `SFRT_TBL_UNUSED,
      MAKER_ID, `SFRT_TBL_REV_MINOR, `SFRT_TBL_REV_MAJOR, `SFRT_TBL_VND_LEN,
      VND_PTR[7:0], VND_PTR[15:8], VND_PTR[23:16],
      `SFRT_TBL_UNUSED
   };

   // ----------------------------------------------------------------
   // lookup
   // ----------------------------------------------------------------
   wire in_hdr = rom.addr < 24'(`SFRT_TBL_HDR_BYTES);
   wire sfrt_byte_t sel = in_hdr ? TBL[rom.addr[4:0]] : `SFRT_TBL_UNUSED;

   always_ff @(posedge rclk) begin
      rom.data <= sel;
   end
endmodule : sfrt_param_rom

// >>> tb/sfrt_cmd_bench.sv
// self-checking bench for the command slice
// host model drives the link; system-side events come from here
`timescale 1ns/1ps
`include "sfrt_params.svh"
module sfrt_cmd_bench;
   import sfrt_pkg::*;
   // arbitrary maker byte, equal to the memory default
   localparam logic [7:0] MAKER_CODE = 8'h5e;
   localparam logic [7:0] TBL [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
      8'hff, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff, MAKER_CODE, 8'h00,
      8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hff};
   logic clock, nrst, lclk, cs_n, qpi, perf, ebusy, eers, esf, psf, busy, res, abt, srst;
   logic rdy, sok;
   logic [2:0] evt;
   sfrt_nibble_t sin;
   logic [3:0] sout, soe;
   int err_total = 0, num_checks = 0, n_res = 0, n_rst = 0, n_abt = 0, rec_cnt = 0;

   sfrt_cmd #(.RESUME_GAP_CYC(16'h0014)) i_dut (
      .clock, .nrst, .link_clk(lclk), .cs_n, .sio_in(sin), .sio_out(sout), .sio_oe(soe),
      .qpi_mode(qpi), .perf_mode(perf), .erase_suspend_evt(evt[0]),
      .program_suspend_evt(evt[1]), .engine_busy(ebusy), .engine_erasing(eers),
      .engine_done_evt(evt[2]), .erase_suspended_flag(esf), .program_suspended_flag(psf),
      .busy, .resume_req(res), .abort_req(abt), .soft_reset(srst), .dev_ready(rdy),
      .suspend_ok(sok));
   sfrt_host_model i_host (.link_clk(lclk), .cs_n, .sio_in(sin), .sio_out(sout), .sio_oe(soe));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      n_res <= n_res + (res === 1'b1);
      n_rst <= n_rst + (srst === 1'b1);
      n_abt <= n_abt + (abt === 1'b1);
      rec_cnt <= (srst === 1'b1) ? 0 : rec_cnt + (rdy === 1'b0);
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic cmd(input logic [7:0] b, input bit q);
      i_host.cmd(b, q);
      @(negedge clock);
   endtask : cmd
   task automatic pulse(input logic [2:0] m);
      @(posedge clock);
      evt <= m;
      @(posedge clock);
      evt <= 3'h0;
      repeat (3) @(negedge clock);
   endtask : pulse
   task automatic wait_ready;
      int k;
      for (k = 0; k < 4000 && rdy !== 1'b1; k++) @(negedge clock);
      if (k == 4000) begin
         err_total++;
         report_and_stop();
      end
   endtask : wait_ready
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_resume;
      int n0;
      pulse(3'h1);
      check(esf, 1);
      n0 = n_res;
      cmd(`SFRT_OP_RESUME, 1'b0);
      check(n_res - n0, 1);
      check({esf, busy, sok}, 3'h2);
      pulse(3'h4);
      repeat (30) @(negedge clock);
      check({busy, sok}, 2'h1);
   endtask : t_resume
   task automatic t_perf;
      int n0;
      pulse(3'h2);
      @(posedge clock);
      perf <= 1'b1;
      n0 = n_res;
      cmd(`SFRT_OP_RESUME, 1'b0);
      check({n_res - n0, psf}, 1);
      @(posedge clock);
      perf <= 1'b0;
      cmd(`SFRT_OP_RESUME, 1'b0);
      check({n_res - n0, psf}, 2);
      pulse(3'h4);
      repeat (30) @(negedge clock);
   endtask : t_perf
   task automatic t_table;
      logic [7:0] b;
      int n;
      for (int k = 0; k < 2; k++) begin
         n = k ? 2 : 25;
         i_host.open_f();
         i_host.shift(`SFRT_OP_TBL_RD, 1'b0);
         i_host.shift(8'h00, 1'b0);
         i_host.shift(8'h00, 1'b0);
         i_host.shift(k ? 8'h13 : 8'h00, 1'b0);
         i_host.shift(8'h00, 1'b0);
         for (int i = 0; i < n; i++) begin
            i_host.get(b);
            check(b, (i + 19 * k) < 24 ? TBL[i + 19 * k] : 8'hff);
         end
         check(soe, 4'h2);
         i_host.close_f();
         check(soe, 4'h0);
      end
   endtask : t_table
   task automatic t_reset(input bit q, input bit eb, input bit ee, input int rc);
      int r0;
      int a0;
      @(posedge clock);
      qpi <= q;
      ebusy <= eb;
      eers <= ee;
      pulse(3'h1);
      // first frame after a mode change only primes the link-side mode synchroniser
      cmd(`SFRT_OP_NOP, q);
      r0 = n_rst;
      a0 = n_abt;
      cmd(`SFRT_OP_RST_ARM, q);
      cmd(`SFRT_OP_NOP, q);
      cmd(`SFRT_OP_RST, q);
      check(n_rst - r0, 0);
      check(esf, 1);
      cmd(`SFRT_OP_RST_ARM, q);
      cmd(`SFRT_OP_RST, q);
      check(n_rst - r0, 1);
      check(n_abt - a0, eb);
      check({esf, psf, rdy}, 3'h0);
      wait_ready();
      check(rec_cnt >= rc - 2 && rec_cnt <= rc + 2, 1);
      @(posedge clock);
      qpi <= 1'b0;
      ebusy <= 1'b0;
      eers <= 1'b0;
      repeat (4) @(negedge clock);
   endtask : t_reset

   initial begin
      nrst = 1'b0;
      qpi = 1'b0;
      perf = 1'b0;
      ebusy = 1'b0;
      eers = 1'b0;
      evt = 3'h0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(negedge clock);
      check({esf, psf, rdy, sok, soe}, 8'h30);
      t_resume();
      t_perf();
      t_table();
      t_reset(1'b0, 1'b0, 1'b0, `SFRT_RECOV_IDLE_CYC);
      t_reset(1'b1, 1'b0, 1'b0, `SFRT_RECOV_IDLE_CYC);
      t_reset(1'b0, 1'b1, 1'b0, `SFRT_RECOV_PGM_CYC);
      t_reset(1'b1, 1'b1, 1'b1, `SFRT_RECOV_ERS_CYC);
      report_and_stop();
   end
endmodule : sfrt_cmd_bench

// >>> tb/sfrt_cmd_properties.sv
// assertions on the ports of the command slice top
// bound into every sfrt_cmd instance; all on the system clock
`timescale 1ns/1ps
module sfrt_cmd_properties #(
   parameter logic [15:0] RESUME_GAP_CYC = 16'h0014
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic [3:0] sio_out,
   input wire logic [3:0] sio_oe,
   input wire logic perf_mode,
   input wire logic erase_suspend_evt,
   input wire logic program_suspend_evt,
   input wire logic engine_busy,
   input wire logic erase_suspended_flag,
   input wire logic program_suspended_flag,
   input wire logic busy,
   input wire logic resume_req,
   input wire logic abort_req,
   input wire logic soft_reset,
   input wire logic dev_ready,
   input wire logic suspend_ok
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   erase_flag_set_a: assert property (erase_suspend_evt |=> erase_suspended_flag)
      else $error("erase suspend flag not set");
   prog_flag_set_a: assert property (program_suspend_evt |=> program_suspended_flag)
      else $error("program suspend flag not set");
   resume_clear_a: assert property (resume_req && !erase_suspend_evt && !program_suspend_evt
      |=> !erase_suspended_flag && !program_suspended_flag)
      else $error("suspend flag survives resume");
   resume_cause_a: assert property (resume_req |-> !$past(perf_mode)
      && ($past(erase_suspended_flag) || $past(program_suspended_flag)))
      else $error("resume without suspend or under enhance mode");
   resume_busy_a: assert property (resume_req |=> busy)
      else $error("busy low after resume");
   suspend_gap_a: assert property (resume_req |=> !suspend_ok [*8])
      else $error("suspend allowed too soon after resume");
   reset_recov_a: assert property (soft_reset |=> !dev_ready [*8])
      else $error("ready too soon after soft reset");
   abort_cause_a: assert property (abort_req |-> soft_reset && $past(busy))
      else $error("abort without a reset during a write");
   reset_abort_a: assert property (soft_reset && $past(engine_busy) |-> abort_req)
      else $error("reset during a write did not abort it");
   oe_release_a: assert property (cs_n |-> sio_oe == 4'h0)
      else $error("output driven while deselected");
   out_lines_a: assert property ((sio_oe & 4'hd) == 4'h0 && (sio_out & 4'hd) == 4'h0)
      else $error("unused output line active");
endmodule : sfrt_cmd_properties

bind sfrt_cmd sfrt_cmd_properties #(.RESUME_GAP_CYC(RESUME_GAP_CYC)) i_props (
   .clock, .nrst, .cs_n, .sio_out, .sio_oe, .perf_mode, .erase_suspend_evt,
   .program_suspend_evt, .engine_busy, .erase_suspended_flag, .program_suspended_flag,
   .busy, .resume_req, .abort_req, .soft_reset, .dev_ready, .suspend_ok);

// >>> tb/sfrt_host_model.sv
// host-side link driver for the command slice
// link clock runs only inside frames; data changes on its falling edge
`timescale 1ns/1ps
module sfrt_host_model (
   output logic link_clk,
   output logic cs_n,
   output sfrt_pkg::sfrt_nibble_t sio_in,
   input wire logic [3:0] sio_out,
   input wire logic [3:0] sio_oe
);
   import sfrt_pkg::*;
   // ----------------------------------------------------------------
   // frame tasks
   // ----------------------------------------------------------------
   initial begin
      link_clk = 1'b0;
      cs_n = 1'b1;
      sio_in = 4'h5;
   end
   task automatic open_f;
      cs_n = 1'b0;
      #15;
   endtask : open_f
   task automatic shift(input logic [7:0] b, input bit q);
      for (int i = 0; i < (q ? 2 : 8); i++) begin
         if (q)
            sio_in = b[7 - 4 * i -: 4];
         else
            sio_in = {~sio_in[3:1], b[7 - i]};
         #15 link_clk = 1'b1;
         #15 link_clk = 1'b0;
      end
   endtask : shift
   task automatic get(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         #15 link_clk = 1'b1;
         b = {b[6:0], sio_oe[1] ? sio_out[1] : 1'bx};
         #15 link_clk = 1'b0;
      end
   endtask : get
   task automatic close_f;
      #15 cs_n = 1'b1;
      sio_in = ~sio_in;
      #200;
   endtask : close_f
   task automatic cmd(input logic [7:0] b, input bit q);
      open_f();
      shift(b, q);
      close_f();
   endtask : cmd
endmodule : sfrt_host_model
